// *** eeprom_page_host.sv ***
// host sequencer that drives a byte-wide page-write eeprom through its pins
`timescale 1ns/1ps
`default_nettype none

module eeprom_page_host #(
  parameter int BYTE_LOAD_WINDOW_CYC = eeprom_host_pkg::BYTE_LOAD_WINDOW_CYC,
  parameter int WRITE_DURATION_CYC   = eeprom_host_pkg::WRITE_DURATION_CYC
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic                                clk_en,
  // user side
  input  wire logic                                req_valid,
  input  wire logic                                req_write,
  input  wire logic [eeprom_host_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [eeprom_host_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic                                hold_strobe,
  output logic                                     req_ready,
  output logic                                     rd_valid,
  output logic      [eeprom_host_pkg::DATA_W-1:0]  rd_data,
  output logic                                     wr_done,
  output logic                                     wr_timeout,
  output logic                                     busy,
  // eeprom pins
  output logic      [eeprom_host_pkg::ADDR_W-1:0]  ee_addr,
  output logic                                     ee_ce_n,
  output logic                                     ee_oe_n,
  output logic                                     ee_we_n,
  output logic      [eeprom_host_pkg::DATA_W-1:0]  ee_dq_o,
  output logic                                     ee_dq_oe,
  input  wire logic [eeprom_host_pkg::DATA_W-1:0]  ee_dq_i,
  input  wire logic                                ee_rdy_i
);
  localparam int AW = eeprom_host_pkg::ADDR_W;
  localparam int DW = eeprom_host_pkg::DATA_W;
  localparam int RW = eeprom_host_pkg::ROW_W;
  localparam int CW = eeprom_host_pkg::COL_W;
  localparam int NW = eeprom_host_pkg::CNT_W;
  localparam int TW = eeprom_host_pkg::TIMER_W;
  localparam int PULSE_CYC = eeprom_host_pkg::WRITE_PULSE_CYC;

  typedef struct packed {
    eeprom_host_pkg::host_state_e state;
    logic [AW-1:0]                addr;
    logic [DW-1:0]                dq_o;
    logic                         dq_oe;
    logic                         ce_n;
    logic                         oe_n;
    logic                         we_n;
    logic [AW-1:0]                last_addr;
    logic [DW-1:0]                last_data;
    logic [RW-1:0]                row;
    logic [NW-1:0]                count;
    logic                         poll;
    logic                         req_ready;
    logic                         rd_valid;
    logic [DW-1:0]                rd_data;
    logic                         wr_done;
    logic                         wr_timeout;
    logic                         busy;
  } host_regs_s;

  localparam host_regs_s REGS_RST = '{state: eeprom_host_pkg::ST_IDLE,
                                      ce_n: 1'h1, oe_n: 1'h1, we_n: 1'h1,
                                      default: '0};

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_q1_r;
  logic rst_sync_n;

  // release passes two flops so no state leaves reset mid-cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_q1_r   <= 1'h0;
      rst_sync_n <= 1'h0;
    end
    else
    begin
      rst_q1_r   <= 1'h1;
      rst_sync_n <= rst_q1_r;
    end
  end

  // ************************************************************
  // timers: one for strobe, access and window, one for the write
  // ************************************************************
  host_regs_s    s_r;
  host_regs_s    s_nxt;
  logic          step_load;
  logic [TW-1:0] step_val;
  logic          step_done;
  logic          wcyc_load;
  logic          wcyc_done;
  logic          row_hit;

  cycle_timer #(.W(TW)) u_step_timer (
    .clk      (clk),
    .rst_n    (rst_sync_n),
    .clk_en   (clk_en),
    .load     (step_load),
    .load_val (step_val),
    .expired  (step_done)
  );

  cycle_timer #(.W(TW)) u_write_timer (
    .clk      (clk),
    .rst_n    (rst_sync_n),
    .clk_en   (clk_en),
    .load     (wcyc_load),
    .load_val (TW'(WRITE_DURATION_CYC - 1)),
    .expired  (wcyc_done)
  );

  // a byte may join the open page only on its row and below the page size
  assign row_hit = req_write && (req_addr[AW-1:CW] == s_r.row)
                   && (s_r.count < NW'(eeprom_host_pkg::PAGE_BYTES)); // see [RQ7] see [RQ8]

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb
  begin
    s_nxt            = s_r;
    step_load        = 1'h0;
    step_val         = '0;
    wcyc_load        = 1'h0;
    s_nxt.rd_valid   = 1'h0;
    s_nxt.wr_done    = 1'h0;
    s_nxt.wr_timeout = 1'h0;
    unique case (s_r.state)
      eeprom_host_pkg::ST_IDLE:
      begin
        s_nxt.req_ready = 1'h1;
        if (req_valid && s_r.req_ready)
        begin
          s_nxt.req_ready = 1'h0;
          s_nxt.addr      = req_addr;
          s_nxt.we_n      = 1'h1; // see [RQ1]
          if (req_write)
          begin
            // address, data and output-high settle a cycle before the strobes
            s_nxt.dq_o  = req_wdata;
            s_nxt.dq_oe = 1'h1;
            s_nxt.oe_n  = 1'h1; // see [RQ3]
            s_nxt.row   = req_addr[AW-1:CW];
            s_nxt.count = '0;
            s_nxt.busy  = 1'h1;
            s_nxt.state = eeprom_host_pkg::ST_WR_SETUP;
          end
          else
          begin
            s_nxt.poll  = 1'h0;
            s_nxt.state = eeprom_host_pkg::ST_RD_ADDR;
          end
        end
      end
      eeprom_host_pkg::ST_WR_SETUP:
      begin
        // both strobes fall together, so the write is strobe controlled
        s_nxt.ce_n  = 1'h0;
        s_nxt.we_n  = 1'h0; // see [RQ3]
        step_load   = 1'h1;
        step_val    = TW'(PULSE_CYC - 1); // see [RQ10]
        s_nxt.state = eeprom_host_pkg::ST_WR_PULSE;
      end
      eeprom_host_pkg::ST_WR_PULSE:
      begin
        // the user may stretch the load; the device timer waits for the rise
        if (step_done && !hold_strobe) // see [RQ10] see [RQ20]
        begin
          s_nxt.we_n      = 1'h1;
          s_nxt.ce_n      = 1'h1;
          s_nxt.last_addr = s_r.addr;
          s_nxt.last_data = s_r.dq_o;
          s_nxt.count     = s_r.count + NW'(1);
          step_load       = 1'h1;
          step_val        = TW'(BYTE_LOAD_WINDOW_CYC - eeprom_host_pkg::WINDOW_MARGIN); // see [RQ12]
          s_nxt.state     = eeprom_host_pkg::ST_WR_REL;
        end
      end
      eeprom_host_pkg::ST_WR_REL:
      begin
        // data held one cycle past the rise for hold time
        s_nxt.dq_oe     = 1'h0;
        s_nxt.req_ready = 1'h1;
        s_nxt.state     = eeprom_host_pkg::ST_PG_OPEN;
      end
      eeprom_host_pkg::ST_PG_OPEN:
      begin
        if (step_done || (req_valid && !row_hit))
        begin
          // page closes: poll the last byte; a foreign request waits
          s_nxt.req_ready = 1'h0;
          s_nxt.poll      = 1'h1;
          s_nxt.addr      = s_r.last_addr; // see [RQ15]
          wcyc_load       = 1'h1; // see [RQ12] see [RQ13]
          s_nxt.state     = eeprom_host_pkg::ST_RD_ADDR;
        end
        else if (req_valid)
        begin
          s_nxt.req_ready = 1'h0;
          s_nxt.addr      = req_addr; // see [RQ9]
          s_nxt.dq_o      = req_wdata;
          s_nxt.dq_oe     = 1'h1;
          s_nxt.state     = eeprom_host_pkg::ST_WR_SETUP;
        end
      end
      eeprom_host_pkg::ST_RD_ADDR:
      begin
        s_nxt.ce_n  = 1'h0; // see [RQ1]
        s_nxt.state = eeprom_host_pkg::ST_RD_CE;
      end
      eeprom_host_pkg::ST_RD_CE:
      begin
        s_nxt.oe_n  = 1'h0; // see [RQ1]
        step_load   = 1'h1;
        step_val    = TW'(eeprom_host_pkg::READ_ACCESS_CYC - 1);
        s_nxt.state = eeprom_host_pkg::ST_RD_WAIT;
      end
      eeprom_host_pkg::ST_RD_WAIT:
      begin
        if (step_done)
        begin
          s_nxt.ce_n = 1'h1;
          s_nxt.oe_n = 1'h1;
          if (!s_r.poll)
          begin
            s_nxt.rd_valid  = 1'h1;
            s_nxt.rd_data   = ee_dq_i;
            s_nxt.req_ready = 1'h1;
            s_nxt.state     = eeprom_host_pkg::ST_IDLE;
          end
          // inverted data means still writing; the pulled-up ready confirms
          else if (((ee_dq_i == s_r.last_data) && ee_rdy_i) || wcyc_done) // see [RQ14] see [RQ19]
          begin
            s_nxt.wr_done    = 1'h1;
            s_nxt.wr_timeout = wcyc_done && (ee_dq_i != s_r.last_data);
            s_nxt.poll       = 1'h0;
            s_nxt.busy       = 1'h0;
            s_nxt.req_ready  = 1'h1;
            s_nxt.state      = eeprom_host_pkg::ST_IDLE;
          end
          else
          begin
            // same read sequence again, select high for one cycle
            s_nxt.state = eeprom_host_pkg::ST_RD_ADDR; // see [RQ17]
          end
        end
      end
      default:
      begin
        s_nxt = REGS_RST;
      end
    endcase
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      s_r <= REGS_RST;
    end
    else if (clk_en)
    begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign req_ready  = s_r.req_ready;
  assign rd_valid   = s_r.rd_valid;
  assign rd_data    = s_r.rd_data;
  assign wr_done    = s_r.wr_done;
  assign wr_timeout = s_r.wr_timeout;
  assign busy       = s_r.busy;
  assign ee_addr    = s_r.addr;
  assign ee_ce_n    = s_r.ce_n;
  assign ee_oe_n    = s_r.oe_n;
  assign ee_we_n    = s_r.we_n;
  assign ee_dq_o    = s_r.dq_o;
  assign ee_dq_oe   = s_r.dq_oe;

  // ************************************************************
  // checks on the pin sequencing
  // ************************************************************
  logic [7:0] we_low_cnt;

  // counts cycles of write low, saturating
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      we_low_cnt <= '0;
    end
    else if (s_r.we_n)
    begin
      we_low_cnt <= '0;
    end
    else if (we_low_cnt != 8'hFF)
    begin
      we_low_cnt <= we_low_cnt + 8'h01;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_sync_n);

  read_order_a : assert property ($fell(ee_oe_n) |-> !ee_ce_n && ($past(ee_ce_n) == 1'h0) && ee_we_n && $stable(ee_addr)) // see [RQ1]
    else $error("output enable fell without select low and write high");

  write_setup_a : assert property ($fell(ee_we_n) |-> !ee_ce_n && ee_oe_n && ee_dq_oe && $stable(ee_addr)) // see [RQ3]
    else $error("write strobe fell outside the write state");

  page_fill_a : assert property (!ee_we_n |-> (s_r.count < NW'(eeprom_host_pkg::PAGE_BYTES)) && (ee_addr[AW-1:CW] == s_r.row)) // see [RQ7]
    else $error("byte load beyond page size or off the page row");

  pulse_width_a : assert property ($rose(ee_we_n) |-> we_low_cnt >= 8'(PULSE_CYC)) // see [RQ10]
    else $error("write strobe shorter than the least pulse width");

  poll_timing_a : assert property ($fell(ee_ce_n) && ee_we_n |=> $fell(ee_oe_n) ##1 !ee_oe_n [*2]) // see [RQ17]
    else $error("read or poll strobes out of sequence");

  stretch_hold_a : assert property (!ee_we_n && hold_strobe && clk_en |=> !ee_we_n) // see [RQ20]
    else $error("write strobe rose while the stretch was held");
endmodule // eeprom_page_host

`default_nettype wire

// *** eeprom_host_pkg.sv ***
// constants and the cycle timer shared by the eeprom page-write host
//
// Contract
// [RQ1] read: address stable, then chip select low, then output enable low, write high
// [RQ2] device passes read address, controls and data straight through its latches
// [RQ3] write starts only with address valid, select low, write low, output high
// [RQ4] device takes address and output state on the later falling select or write
// [RQ5] device takes write data on the earlier rising write or select edge
// [RQ6] device erases target bytes itself before storing them
// [RQ7] one page load holds one to 64 byte writes, any columns, any order
// [RQ8] device keeps the row of the first byte until the write cycle ends
// [RQ9] device takes the column afresh on every byte load
// [RQ10] host holds write low at least the least write pulse width
// [RQ11] device page timer runs from each rising write edge, held while low
// [RQ12] no new load within the window ends the page; internal write lasts 10 ms
// [RQ13] device ignores write attempts during the internal write
// [RQ14] reads during the internal write return the inverse of the last byte
// [RQ15] after the internal write, the last address reads back its true byte
// [RQ16] polling during a page load returns the inverse of the latest byte
// [RQ17] a polling read uses the same signalling and timing as a normal read
// [RQ18] ready line goes low after falling write, high when the write timer ends
// [RQ19] ready line only pulls low or floats; a pull-up gives the high
// [RQ20] host stretches a load by holding the strobe low; timer waits for the rise
// [RQ21] device writes nothing outside the one defined write state
// [RQ22] pulse width, load window and write duration are parameters, write 10 ms; the host takes the pulse width only from the package constant WRITE_PULSE_CYC
`timescale 1ns/1ps
`default_nettype none

package eeprom_host_pkg;
  // ************************************************************
  // geometry of the array and the page
  // ************************************************************
  localparam int ADDR_W     = 13;
  localparam int DATA_W     = 8;
  localparam int COL_W      = 6;
  localparam int ROW_W      = ADDR_W - COL_W;
  localparam int PAGE_BYTES = 64;
  localparam int CNT_W      = 7;
  localparam int TIMER_W    = 24;

  // ************************************************************
  // timing, in printed units, then in cycles of a 10 ns clock
  // ************************************************************
  localparam int CLK_PERIOD_NS        = 10;
  localparam int WRITE_PULSE_MIN_NS   = 150;
  localparam int BYTE_LOAD_WINDOW_NS  = 100000;
  localparam int READ_ACCESS_NS       = 250;
  localparam int WRITE_DURATION_MS    = 10;
  localparam int NS_PER_MS            = 1000000;
  // least times round up, longest round down
  localparam int WRITE_PULSE_CYC      = (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC      = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_NS / CLK_PERIOD_NS;
  localparam int WRITE_DURATION_CYC   = WRITE_DURATION_MS * NS_PER_MS / CLK_PERIOD_NS;
  // cycles lost between taking a request and the next falling write edge
  localparam int WINDOW_MARGIN        = 4;

  // ************************************************************
  // host sequencer states
  // ************************************************************
  typedef enum logic [7:0] {
    ST_IDLE     = 8'h01,
    ST_WR_SETUP = 8'h02,
    ST_WR_PULSE = 8'h04,
    ST_WR_REL   = 8'h08,
    ST_PG_OPEN  = 8'h10,
    ST_RD_ADDR  = 8'h20,
    ST_RD_CE    = 8'h40,
    ST_RD_WAIT  = 8'h80
  } host_state_e;
endpackage

// ************************************************************
// loadable down counter; expired while the count sits at zero
// ************************************************************
module cycle_timer #(
  parameter int W = eeprom_host_pkg::TIMER_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } timer_regs_s;

  timer_regs_s t_r;
  timer_regs_s t_nxt;

  // load wins over counting so a restart is never lost
  always_comb
  begin
    t_nxt = t_r;
    if (load)
    begin
      t_nxt.cnt = load_val;
    end
    else if (t_r.cnt != '0)
    begin
      t_nxt.cnt = t_r.cnt - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t_r <= '0;
    end
    else if (clk_en)
    begin
      t_r <= t_nxt;
    end
  end

  assign expired = (t_r.cnt == '0);
endmodule // cycle_timer

`default_nettype wire

// *** eeprom_model.sv ***
// behavioural model of the byte-wide page-write eeprom on the far side of the host
`timescale 1ns/1ps
`default_nettype none

module eeprom_model #(
  parameter int WIN_CYC  = 40,
  parameter int FAST_CYC = 120,
  parameter int SLOW_CYC = 400
) (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [12:0] addr,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out,
  output logic             rdy_low
);
  // ************
  // array, page buffer and load state
  // ************
  logic [7:0]  mem [0:8191];
  logic [7:0]  page [0:63];
  logic [63:0] pmask;
  logic [6:0]  row;
  logic [5:0]  col;
  logic [7:0]  last;
  logic [7:0]  junk;
  logic        open_r;
  logic        timing;
  logic        writing;
  int          cnt;
  // only the one defined write state loads a byte
  wire load = !ce_n && !we_n && oe_n;
  wire rd   = !ce_n && !oe_n && we_n;

  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'hFF;
    pmask   = '0;
    open_r  = 1'b0;
    timing  = 1'b0;
    writing = 1'b0;
    rdy_low = 1'b0;
    junk    = 8'h5A;
    last    = 8'h00;
  end

  // later falling strobe: column every time, row only on the first byte
  always @(posedge load)
    if (!writing)
    begin
      col = addr[5:0];
      if (!open_r)
        row = addr[12:6];
      open_r  = 1'b1;
      timing  = 1'b0;
      rdy_low = 1'b1;
    end

  // earlier rising strobe: data taken, page timer starts
  always @(negedge load)
    if (open_r && !writing)
    begin
      page[col]  = dq_in;
      pmask[col] = 1'b1;
      last       = dq_in;
      timing     = 1'b1;
      cnt        = 0;
    end

  // page timer, then the internal write; stored bytes replace old ones whole
  // runs on the falling clock so the host never samples a change mid-edge
  always @(negedge clk)
  begin
    junk <= ~junk;
    if (timing)
    begin
      cnt = cnt + 1;
      if (cnt >= WIN_CYC)
      begin
        timing  = 1'b0;
        open_r  = 1'b0;
        writing = 1'b1;
        cnt     = 0;
      end
    end
    else if (writing)
    begin
      cnt = cnt + 1;
      if (cnt >= (slow ? SLOW_CYC : FAST_CYC))
      begin
        for (int i = 0; i < 64; i++)
          if (pmask[i])
            mem[{row, i[5:0]}] = page[i];
        pmask   = '0;
        writing = 1'b0;
        rdy_low = 1'b0;
      end
    end
  end

  // reads pass through; busy reads show the inverse; idle bus shows noise
  assign dq_out = !rd ? junk : (open_r || writing) ? ~last : mem[addr];

endmodule // eeprom_model

`default_nettype wire

// *** tb_eeprom_page_host.sv ***
// self-checking bench for the eeprom page-write host against the device model
`timescale 1ns/1ps
`default_nettype none

module tb_eeprom_page_host;
  // ************
  // wiring
  // ************
  localparam int WIN  = 40;
  localparam int WDUR = 200;
  logic        clk, rst_n, clk_en, req_valid, req_write, hold_strobe, slow;
  logic [12:0] req_addr, ee_addr;
  logic [7:0]  req_wdata, rd_data, ee_dq_o, dev_q, dq_bus;
  logic        req_ready, rd_valid, wr_done, wr_timeout, busy;
  logic        ee_ce_n, ee_oe_n, ee_we_n, ee_dq_oe, rdy_low, ee_rdy;
  logic [7:0]  shadow [0:8191];
  logic [31:0] rnd;
  logic [6:0]  row;
  int          fails, checked, cyc, done_cnt, to_cnt, pages, exp_to, cnt, n;

  assign dq_bus = ee_dq_oe ? ee_dq_o : dev_q;
  assign ee_rdy = rdy_low ? 1'b0 : 1'b1; // pull-up

  eeprom_page_host #(.BYTE_LOAD_WINDOW_CYC(WIN), .WRITE_DURATION_CYC(WDUR)) eeprom_page_host_inst (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .hold_strobe(hold_strobe), .req_ready(req_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .wr_done(wr_done), .wr_timeout(wr_timeout), .busy(busy),
    .ee_addr(ee_addr), .ee_ce_n(ee_ce_n), .ee_oe_n(ee_oe_n), .ee_we_n(ee_we_n),
    .ee_dq_o(ee_dq_o), .ee_dq_oe(ee_dq_oe), .ee_dq_i(dq_bus), .ee_rdy_i(ee_rdy));

  eeprom_model #(.WIN_CYC(WIN)) eeprom_model_inst (
    .clk(clk), .slow(slow), .addr(ee_addr), .ce_n(ee_ce_n), .oe_n(ee_oe_n),
    .we_n(ee_we_n), .dq_in(dq_bus), .dq_out(dev_q), .rdy_low(rdy_low));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // completion counters and hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (wr_done === 1'b1)
      done_cnt++;
    if (wr_timeout === 1'b1)
      to_cnt++;
    if (cyc >= 80000)
    begin
      fails++;
      give_verdict();
    end
  end

  // ************
  // helpers
  // ************
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // request held from just after an edge until the edge that takes it
  task automatic issue(input logic w, input logic [12:0] a, input logic [7:0] d);
    logic took;
    int   k;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_write = w;
    req_addr  = a;
    req_wdata = d;
    k = 0;
    do
    begin
      // with a page open, a read or another row is held off until its write completes and busy drops
      took = req_ready && (!busy || (w && a[12:6] == ee_addr[12:6]));
      @(posedge clk);
      #1;
      k++;
    end
    while (took !== 1'b1 && k < 4000);
    req_valid = 1'b0;
    if (took !== 1'b1)
      fails++;
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    int k;
    issue(1'b1, a, d);
    shadow[a] = d;
    k = 0;
    while (ee_we_n !== 1'b0 && k < 8)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check({4'h0, ee_ce_n, ee_oe_n, ee_dq_oe, ee_rdy}, 8'h06);
    check(ee_dq_o, d);
    check(ee_addr[7:0], a[7:0]);
  endtask

  // a short clock-enable freeze is thrown into each read whose rnd[1:0] is nonzero
  task automatic rd(input logic [12:0] a);
    int k;
    issue(1'b0, a, 8'h00);
    clk_en = 1'b0;
    repeat (rnd[1:0]) @(posedge clk);
    #1 clk_en = 1'b1;
    k = 0;
    while (rd_valid !== 1'b1 && k < 2000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check({7'h0, rd_valid}, 8'h01);
    check(rd_data, shadow[a]);
  endtask

  task automatic wait_pages(input int more);
    int k;
    pages += more;
    k = 0;
    while (done_cnt < pages && k < 3000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    check(done_cnt[7:0], pages[7:0]);
    check(to_cnt[7:0], exp_to[7:0]);
  endtask

  // ************
  // scenarios
  // ************
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    hold_strobe = 1'b0;
    slow = 1'b0;
    rnd = 32'h8E0A;
    {fails, checked, cyc, done_cnt, to_cnt, pages, exp_to} = '0;
    for (int i = 0; i < 8192; i++)
      shadow[i] = 8'hFF;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    // erased array read at scattered places
    repeat (4)
    begin
      rnd = step(rnd);
      rd(rnd[12:0]);
    end
    // full page in scrambled order, one byte, then random sizes
    for (int p = 0; p < 4; p++)
    begin
      rnd = step(rnd);
      row = rnd[18:12];
      cnt = (p == 0) ? 64 : (p == 1) ? 1 : 1 + rnd[5:0] % 63;
      for (int k = 0; k < cnt; k++)
      begin
        rnd = step(rnd);
        wr({row, (p == 0) ? 6'(k * 37 + 5) : rnd[5:0]}, rnd[15:8]);
      end
      wait_pages(1);
      for (int c = 0; c < 64; c++)
        rd({row, c[5:0]});
    end
    // another row, then a read, each closes the open page first
    rnd = step(rnd);
    wr(rnd[12:0], 8'h3C);
    wr(rnd[12:0] ^ 13'h0040, 8'hC3);
    wait_pages(2);
    rd(rnd[12:0]);
    rd(rnd[12:0] ^ 13'h0040);
    wr(rnd[12:0] ^ 13'h0001, 8'h5A);
    rd(rnd[12:0] ^ 13'h0001);
    wait_pages(1);
    // stretched load keeps the strobe low past the window
    hold_strobe = 1'b1;
    wr(13'h0A55, 8'h81);
    repeat (2 * WIN) @(posedge clk);
    #1 check({7'h0, ee_we_n}, 8'h00);
    check({7'h0, busy}, 8'h01);
    hold_strobe = 1'b0;
    wait_pages(1);
    rd(13'h0A55);
    // slow device: host gives up, the data still lands later
    slow = 1'b1;
    exp_to = 1;
    wr(13'h1F00, 8'h96);
    wait_pages(1);
    n = 0;
    while (ee_rdy !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check({7'h0, ee_rdy}, 8'h01);
    slow = 1'b0;
    rd(13'h1F00);
    give_verdict();
  end

endmodule // tb_eeprom_page_host

`default_nettype wire
